// [hdl/egcr_pkg.sv]
// Package: register map, field layout and codes of the configuration bank
// Functional notes
// - Excitation control upper nibble reads fixed revision; writes ignored.
// - Ready-mode bit 0: shared pin carries data only; 1: also ready low.
// - Dedicated ready pin always goes low when a new result exists.
// - Three-bit magnitude code sets both sources; 101 and 111 undefined.
// - Source one route bits 7:4: inputs 0-7, outputs one/two, 11xx off.
// - Source two route bits 3:0, same encoding, resets disconnected.
// - Inputs 4-7 and excitation outputs only work on eight-input variant.
// - Pin enable bit 0 leaves port off; 1 applies it to shared pin.
// - Direction bit 0 makes pin output, 1 makes it input.
// - Output pin reads stored data; input pin write sets stored value only.
package egcr_pkg;
    localparam int unsigned CLOCK_HZ = 20_000_000;

    localparam logic [3:0] IDX_EXC_CTRL = 4'hA;
    localparam logic [3:0] IDX_ROUTE    = 4'hB;
    localparam logic [3:0] IDX_PIN_EN   = 4'hC;
    localparam logic [3:0] IDX_PIN_DIR  = 4'hD;
    localparam logic [3:0] IDX_PIN_DATA = 4'hE;
    localparam logic [3:0] IDX_STATUS   = 4'hF;

    localparam logic [7:0] RST_ROUTE    = 8'hFF;
    localparam logic [7:0] RST_PIN_EN   = 8'h00;
    localparam logic [7:0] RST_PIN_DIR  = 8'h00;
    localparam logic [7:0] RST_PIN_DATA = 8'h00;
    localparam logic [2:0] RST_MAG      = 3'h0;
    localparam logic       RST_RDY_MODE = 1'b0;

    localparam int REV_HI    = 7;
    localparam int REV_LO    = 4;
    localparam int RDY_BIT   = 3;
    localparam int MAG_HI    = 2;
    localparam int MAG_LO    = 0;
    localparam int R1_HI     = 7;
    localparam int R1_LO     = 4;
    localparam int R2_HI     = 3;
    localparam int R2_LO     = 0;
    localparam int NUM_PINS  = 8;
    localparam int NUM_AIN   = 8;

    // Magnitude codes
    localparam logic [2:0] MAG_OFF  = 3'h0;
    localparam logic [2:0] MAG_50   = 3'h1;
    localparam logic [2:0] MAG_100  = 3'h2;
    localparam logic [2:0] MAG_250  = 3'h3;
    localparam logic [2:0] MAG_750  = 3'h4;
    localparam logic [2:0] MAG_1000 = 3'h6;

    // Magnitude in microamps
    localparam logic [9:0] UA_OFF  = 10'h000;
    localparam logic [9:0] UA_50   = 10'h032;
    localparam logic [9:0] UA_100  = 10'h064;
    localparam logic [9:0] UA_250  = 10'h0FA;
    localparam logic [9:0] UA_750  = 10'h2EE;
    localparam logic [9:0] UA_1000 = 10'h3E8;

    // Route decode outputs
    localparam logic [9:0] SEL_NONE = 10'h000;
    localparam logic [9:0] SEL_OUT1 = 10'h100;
    localparam logic [9:0] SEL_OUT2 = 10'h200;
    localparam logic [7:0] LOW_AIN_MASK = 8'h0F;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam logic [1:0] ADDR_LSB_ZERO = 2'h0;
    localparam logic [1:0] HRESP_OKAY    = 2'h0;

    typedef enum logic [1:0] {
        EGCR_IDLE = 2'b01,
        EGCR_DATA = 2'b10
    } egcr_bus_state_t;
endpackage : egcr_pkg

// [hdl/egcr_cfg_if.sv]
// Interface: configuration fields from the bank to the route decoder
interface egcr_cfg_if;
    logic [2:0] current_magnitude;
    logic [3:0] source_one_route;
    logic [3:0] source_two_route;
    logic       eight_input;
    logic [9:0] src_one_sel;
    logic [9:0] src_two_sel;
    logic [9:0] src_ua;

    modport bank (
        output current_magnitude,
        output source_one_route,
        output source_two_route,
        output eight_input,
        input  src_one_sel,
        input  src_two_sel,
        input  src_ua
    );
    modport dec (
        input  current_magnitude,
        input  source_one_route,
        input  source_two_route,
        input  eight_input,
        output src_one_sel,
        output src_two_sel,
        output src_ua
    );
endinterface : egcr_cfg_if

// [hdl/egcr_route_dec.sv]
// Decoder: current source routing and magnitude
module egcr_route_dec (
    egcr_cfg_if.dec cfg
);
    // Bits 7:0 analog inputs, 8 output one, 9 output two
    function automatic logic [9:0] route_sel(
        input logic [3:0] code,
        input logic       big
    );
        logic [9:0] sel;
        sel = egcr_pkg::SEL_NONE;
        if (code[3] == 1'b0) begin
            sel = 10'(10'h001 << code[2:0]);
        end else if (code[2] == 1'b0) begin
            sel = code[0] ? egcr_pkg::SEL_OUT2 : egcr_pkg::SEL_OUT1;
        end
        // Small variant honours only the low inputs
        if (!big) begin
            sel = {2'h0, sel[7:0] & egcr_pkg::LOW_AIN_MASK};
        end
        return sel;
    endfunction : route_sel

    assign cfg.src_one_sel = route_sel(cfg.source_one_route,
                                       cfg.eight_input);
    assign cfg.src_two_sel = route_sel(cfg.source_two_route,
                                       cfg.eight_input);

    // Undefined codes leave the sources off
    always_comb begin
        unique case (cfg.current_magnitude)
            egcr_pkg::MAG_50:   cfg.src_ua = egcr_pkg::UA_50;
            egcr_pkg::MAG_100:  cfg.src_ua = egcr_pkg::UA_100;
            egcr_pkg::MAG_250:  cfg.src_ua = egcr_pkg::UA_250;
            egcr_pkg::MAG_750:  cfg.src_ua = egcr_pkg::UA_750;
            egcr_pkg::MAG_1000: cfg.src_ua = egcr_pkg::UA_1000;
            default:            cfg.src_ua = egcr_pkg::UA_OFF;
        endcase
    end
endmodule : egcr_route_dec

// [hdl/egcr_regs.sv]
// Top: configuration register bank with AHB-Lite slave and pin control
//
// The AHB-Lite register port was left to the implementer.
module egcr_regs #(
    parameter logic [3:0] REVISION = 4'h5, // Arbitrary value
    parameter bit         EIGHT_INPUT = 1'b1
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        result_ready,
    input  wire logic        continuous_read,
    input  wire logic        serial_data,
    output logic             shared_output_pin,
    output logic             conversion_ready_n,
    output logic      [2:0]  current_magnitude,
    output logic      [9:0]  source_one_sel,
    output logic      [9:0]  source_two_sel,
    output logic      [9:0]  source_current_ua,
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe_n,
    output logic      [7:0]  pin_sample_en
);
    logic [2:0]  mag_ff;
    logic        rdy_mode_ff;
    logic [7:0]  route_ff;
    logic [7:0]  pin_en_ff;
    logic [7:0]  pin_dir_ff;
    logic [7:0]  pin_data_ff;
    logic [7:0]  pin_meta_ff;
    logic [7:0]  pin_sync_ff;
    logic        wr_pend_ff;
    logic [3:0]  wr_idx_ff;
    logic [31:0] rdata_ff;
    logic        rdy_out_ff;
    logic        shared_ff;
    logic        result_meta_ff;
    logic        result_sync_ff;
    logic        cont_meta_ff;
    logic        cont_sync_ff;
    logic        serial_meta_ff;
    logic        serial_sync_ff;
    egcr_pkg::egcr_bus_state_t state_ff;

    egcr_cfg_if cfg ();

    egcr_route_dec u_dec (
        .cfg (cfg)
    );

    assign cfg.current_magnitude = mag_ff;
    assign cfg.source_one_route  = route_ff[egcr_pkg::R1_HI:egcr_pkg::R1_LO];
    assign cfg.source_two_route  = route_ff[egcr_pkg::R2_HI:egcr_pkg::R2_LO];
    assign cfg.eight_input       = EIGHT_INPUT;

    // Bus decode
    wire        addr_ok   = haddr[1:0] == egcr_pkg::ADDR_LSB_ZERO
                            && haddr[31:6] == 26'h0;
    wire        bus_req   = hsel && hready && htrans[1];
    wire [3:0]  req_idx   = haddr[5:2];
    wire        wr_take   = bus_req && hwrite && addr_ok;
    wire        rd_take   = bus_req && !hwrite;
    wire [7:0]  wb        = hwdata[7:0];

    wire wr_exc  = wr_pend_ff && wr_idx_ff == egcr_pkg::IDX_EXC_CTRL;
    wire wr_rte  = wr_pend_ff && wr_idx_ff == egcr_pkg::IDX_ROUTE;
    wire wr_en   = wr_pend_ff && wr_idx_ff == egcr_pkg::IDX_PIN_EN;
    wire wr_dir  = wr_pend_ff && wr_idx_ff == egcr_pkg::IDX_PIN_DIR;
    wire wr_dat  = wr_pend_ff && wr_idx_ff == egcr_pkg::IDX_PIN_DATA;

    // Revision nibble is not writable storage
    wire [7:0] exc_rd = {REVISION, rdy_mode_ff, mag_ff};

    // Output and disabled pins read back the stored bit, enabled inputs the synced pin
    wire [7:0] pin_active = pin_en_ff;
    wire [7:0] data_rd = (pin_dir_ff & pin_active & pin_sync_ff)
                         | (~(pin_dir_ff & pin_active) & pin_data_ff);

    // Status: synced ready and continuous read levels
    wire [7:0] status_rd = {6'h00, cont_sync_ff, result_sync_ff};

    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (addr_ok) begin
            unique case (req_idx)
                egcr_pkg::IDX_EXC_CTRL: rd_mux = exc_rd;
                egcr_pkg::IDX_ROUTE:    rd_mux = route_ff;
                egcr_pkg::IDX_PIN_EN:   rd_mux = pin_en_ff;
                egcr_pkg::IDX_PIN_DIR:  rd_mux = pin_dir_ff;
                egcr_pkg::IDX_PIN_DATA: rd_mux = data_rd;
                egcr_pkg::IDX_STATUS:   rd_mux = status_rd;
                default:                rd_mux = 8'h00;
            endcase
        end
    end

    wire [7:0] nxt_pin_data = wr_dat ? wb : pin_data_ff;

    // Bus state
    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff   <= egcr_pkg::EGCR_IDLE;
            wr_pend_ff <= 1'b0;
            wr_idx_ff  <= 4'h0;
            rdata_ff   <= 32'h0;
        end else begin
            state_ff   <= bus_req ? egcr_pkg::EGCR_DATA
                                  : egcr_pkg::EGCR_IDLE;
            wr_pend_ff <= wr_take;
            wr_idx_ff  <= req_idx;
            rdata_ff   <= rd_take ? {24'h0, rd_mux} : rdata_ff;
        end
    end

    // Configuration registers
    always_ff @(posedge clock) begin
        if (reset) begin
            mag_ff      <= egcr_pkg::RST_MAG;
            rdy_mode_ff <= egcr_pkg::RST_RDY_MODE;
            route_ff    <= egcr_pkg::RST_ROUTE;
            pin_en_ff   <= egcr_pkg::RST_PIN_EN;
            pin_dir_ff  <= egcr_pkg::RST_PIN_DIR;
            pin_data_ff <= egcr_pkg::RST_PIN_DATA;
        end else begin
            if (wr_exc) begin
                mag_ff      <= wb[egcr_pkg::MAG_HI:egcr_pkg::MAG_LO];
                rdy_mode_ff <= wb[egcr_pkg::RDY_BIT];
            end
            if (wr_rte) begin
                route_ff <= wb;
            end
            if (wr_en) begin
                pin_en_ff <= wb;
            end
            if (wr_dir) begin
                pin_dir_ff <= wb;
            end
            pin_data_ff <= nxt_pin_data;
        end
    end

    // Two-stage synchronisers for outside levels
    always_ff @(posedge clock) begin
        if (reset) begin
            pin_meta_ff    <= 8'h00;
            pin_sync_ff    <= 8'h00;
            result_meta_ff <= 1'b0;
            result_sync_ff <= 1'b0;
            cont_meta_ff   <= 1'b0;
            cont_sync_ff   <= 1'b0;
            serial_meta_ff <= 1'b0;
            serial_sync_ff <= 1'b0;
        end else begin
            pin_meta_ff    <= pin_in & pin_active;
            pin_sync_ff    <= pin_meta_ff;
            result_meta_ff <= result_ready;
            result_sync_ff <= result_meta_ff;
            cont_meta_ff   <= continuous_read;
            cont_sync_ff   <= cont_meta_ff;
            serial_meta_ff <= serial_data;
            serial_sync_ff <= serial_meta_ff;
        end
    end

    // Ready indication; combined pin only meaningful with continuous read
    wire nxt_rdy_out = !result_sync_ff;
    wire nxt_shared  = (rdy_mode_ff && result_sync_ff)
                       ? 1'b0 : serial_sync_ff;

    always_ff @(posedge clock) begin
        if (reset) begin
            rdy_out_ff <= 1'b1;
            shared_ff  <= 1'b0;
        end else begin
            rdy_out_ff <= nxt_rdy_out;
            shared_ff  <= nxt_shared;
        end
    end

    assign hrdata             = rdata_ff;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign shared_output_pin  = shared_ff;
    assign conversion_ready_n = rdy_out_ff;
    assign current_magnitude  = mag_ff;
    assign source_one_sel     = cfg.src_one_sel;
    assign source_two_sel     = cfg.src_two_sel;
    assign source_current_ua  = cfg.src_ua;
    // Drive only enabled output pins; disabled ones float for analog use
    assign pin_out       = pin_data_ff & pin_active & ~pin_dir_ff;
    assign pin_oe_n      = ~(pin_active & ~pin_dir_ff);
    assign pin_sample_en = pin_active & pin_dir_ff;
endmodule : egcr_regs

// [dv/egcr_regs_chk.sv]
// Checker: decode, pin and bus relations of the configuration bank
module egcr_regs_chk #(
    parameter logic [3:0] REVISION    = 4'h5,
    parameter bit         EIGHT_INPUT = 1'b1
) (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        result_ready,
    input wire logic        serial_data,
    input wire logic        shared_output_pin,
    input wire logic        conversion_ready_n,
    input wire logic [2:0]  current_magnitude,
    input wire logic [9:0]  source_one_sel,
    input wire logic [9:0]  source_two_sel,
    input wire logic [9:0]  source_current_ua,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe_n,
    input wire logic [7:0]  pin_sample_en
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [31:0] addr_ff;
    logic        wpend_ff;
    logic [3:0]  exc_ff;
    logic [7:0]  route_ff;
    wire         take = hsel && hready && htrans[1];
    wire         rd_take = take && !hwrite;

    // Mirror of written fields, updated on the data-phase edge
    always_ff @(posedge clock) begin
        addr_ff  <= haddr;
        wpend_ff <= !reset && take && hwrite;
        if (reset) begin
            exc_ff   <= 4'h0;
            route_ff <= 8'hFF;
        end else if (wpend_ff && addr_ff == 32'h28) begin
            exc_ff <= hwdata[3:0];
        end else if (wpend_ff && addr_ff == 32'h2C) begin
            route_ff <= hwdata[7:0];
        end
    end

    function automatic logic [9:0] sel_of(input logic [3:0] c);
        return (c[3:2] == 2'h3 || (!EIGHT_INPUT && c[3:2] != 2'h0)) ? 10'h000
            : c[3] ? (c[0] ? 10'h200 : 10'h100) : 10'h001 << c[2:0];
    endfunction : sel_of

    function automatic logic [9:0] ua_of(input logic [2:0] m);
        case (m)
            3'h1: return 10'h032;
            3'h2: return 10'h064;
            3'h3: return 10'h0FA;
            3'h4: return 10'h2EE;
            3'h6: return 10'h3E8;
            default: return 10'h000;
        endcase
    endfunction : ua_of

    sequence read_of(logic [31:0] a);
        rd_take && haddr == a;
    endsequence
    sequence data_only_steady;
        (!exc_ff[3] && serial_data && result_ready)[*4];
    endsequence

    rev_read_fixed_a: assert property (read_of(32'h28)
        |=> hrdata == {24'h0, REVISION, hrdata[3:0]})
        else $error("revision nibble wrong on read");
    read_data_hold_a: assert property (!$past(rd_take) |-> $stable(hrdata))
        else $error("read data changed without a read");
    data_only_pin_a: assert property (data_only_steady
        |=> shared_output_pin)
        else $error("shared pin not carrying data in data-only mode");
    ready_on_pin_a: assert property ((exc_ff[3] && result_ready)[*4]
        |=> !shared_output_pin)
        else $error("shared pin not low for ready");
    ready_pin_low_a: assert property (result_ready[*4]
        |=> !conversion_ready_n)
        else $error("ready pin not low with result pending");
    ready_pin_idle_a: assert property (!result_ready[*4]
        |=> conversion_ready_n)
        else $error("ready pin low without result");
    mag_written_a: assert property (
        current_magnitude == exc_ff[2:0])
        else $error("magnitude differs from written code");
    mag_current_a: assert property (
        source_current_ua == ua_of(current_magnitude))
        else $error("current value wrong for magnitude code");
    route_one_a: assert property (
        source_one_sel == sel_of(route_ff[7:4]))
        else $error("source one routing wrong");
    route_two_a: assert property (
        source_two_sel == sel_of(route_ff[3:0]))
        else $error("source two routing wrong");
    pin_gate_a: assert property (
        (pin_out & pin_oe_n) == 8'h00
        && (pin_sample_en & ~pin_oe_n) == 8'h00)
        else $error("pin driven while released or sampled while driven");
endmodule : egcr_regs_chk

bind egcr_regs egcr_regs_chk #(.REVISION(REVISION), .EIGHT_INPUT(EIGHT_INPUT))
    u_chk (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .result_ready(result_ready), .serial_data(serial_data),
    .shared_output_pin(shared_output_pin),
    .conversion_ready_n(conversion_ready_n),
    .current_magnitude(current_magnitude), .source_one_sel(source_one_sel),
    .source_two_sel(source_two_sel), .source_current_ua(source_current_ua),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_sample_en(pin_sample_en));

// [dv/egcr_host_model.sv]
// Host model: AHB-Lite master that programs the bank
module egcr_host_model (
    input  wire logic        clock,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // Single word transfer; waits on hready with no assumed latency
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= egcr_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge clock); while (!hready);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (!hready);
        q = hrdata;
        // Released lines show junk so a stale value cannot pass
        hsel   <= 1'b0;
        haddr  <= ~a;
        hwdata <= ~d;
    endtask : xfer
endmodule : egcr_host_model

// [dv/test_excitation_gpio_config_regs.sv]
// Testbench: register access, decode and pin checks of the bank
module test_excitation_gpio_config_regs;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] REV = 4'h9; // Arbitrary value
    logic        clock, reset, hsel, hwrite, hreadyout, hresp, result_ready;
    logic        continuous_read, serial_data, shared_output_pin, ready_n;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, current_magnitude;
    logic [9:0]  one_sel, two_sel, ua, small_one;
    logic [7:0]  pin_in, pin_out, pin_oe_n, pin_sample_en, pin_ext;
    int          err_total, samples_checked, cycles;

    // Wire level: design drives where enabled, outside source elsewhere
    assign pin_in = (pin_out & ~pin_oe_n) | (pin_ext & pin_oe_n);

    egcr_regs #(.REVISION(REV), .EIGHT_INPUT(1'b1)) DUT (.clock(clock),
        .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .result_ready(result_ready), .continuous_read(continuous_read),
        .serial_data(serial_data), .shared_output_pin(shared_output_pin),
        .conversion_ready_n(ready_n), .current_magnitude(current_magnitude),
        .source_one_sel(one_sel), .source_two_sel(two_sel),
        .source_current_ua(ua), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_sample_en(pin_sample_en));
    egcr_regs #(.REVISION(REV), .EIGHT_INPUT(1'b0)) dut_small (.clock(clock),
        .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(), .hreadyout(), .hresp(), .result_ready(result_ready),
        .continuous_read(continuous_read), .serial_data(serial_data),
        .shared_output_pin(), .conversion_ready_n(), .current_magnitude(),
        .source_one_sel(small_one), .source_two_sel(), .source_current_ua(),
        .pin_in(pin_in), .pin_out(), .pin_oe_n(), .pin_sample_en());
    egcr_host_model host (.clock(clock), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected reg at %0t: %h vs %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected pin at %0t: %h vs %h", $time, got, exp);
        end
    endtask : chk_pin

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        host.xfer(1'b0, a, 32'h0, q);
        chk_reg(q, exp);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic t_reset;
        @(posedge clock);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rd(32'h28, {24'h0, REV, 4'h0});
        rd(32'h2C, 32'hFF);
        rd(32'h30, 32'h00);
        rd(32'h34, 32'h00);
        chk_pin(pin_oe_n, 8'hFF);
        chk_pin(hresp, 10'h0);
    endtask : t_reset

    task automatic t_control;
        wr(32'h28, 32'hFF);
        rd(32'h28, {24'h0, REV, 4'hF});
        // Reference taken as on before any nonzero code
        for (int m = 0; m < 8; m++) begin
            wr(32'h28, 32'(m));
            tick(1);
            chk_pin(current_magnitude, m[9:0]);
        end
        wr(32'h28, 32'h6);
        tick(1);
        chk_pin(ua, 10'h3E8);
    endtask : t_control

    task automatic t_route;
        for (int c = 0; c < 16; c++) begin
            wr(32'h2C, {24'h0, c[3:0], ~c[3:0]});
            tick(1);
            chk_pin(small_one, c < 4 ? 10'h001 << c : 10'h000);
        end
        wr(32'h2C, 32'h94);
        tick(1);
        chk_pin(one_sel, 10'h200);
        chk_pin(two_sel, 10'h010);
    endtask : t_route

    task automatic t_pins;
        wr(32'h30, 32'hF0);
        wr(32'h34, 32'h30);
        wr(32'h38, 32'hFF);
        tick(1);
        chk_pin(pin_out, 8'hC0);
        chk_pin(pin_oe_n, 8'h3F);
        chk_pin(pin_sample_en, 8'h30);
        rd(32'h38, 32'hEF);
        pin_ext <= 8'h5A;
        wr(32'h38, 32'h00);
        tick(1);
        chk_pin(pin_oe_n, 8'h3F);
        rd(32'h38, 32'h10);
    endtask : t_pins

    task automatic t_ready;
        serial_data  <= 1'b1;
        result_ready <= 1'b1;
        tick(5);
        chk_pin(ready_n, 10'h0);
        chk_pin(shared_output_pin, 10'h1);
        rd(32'h3C, 32'h3);
        // Continuous read stays on while combined mode is used
        wr(32'h28, 32'h08);
        tick(2);
        chk_pin(shared_output_pin, 10'h0);
        chk_pin(ready_n, 10'h0);
        @(posedge clock);
        result_ready <= 1'b0;
        tick(5);
        chk_pin(ready_n, 10'h1);
        chk_pin(shared_output_pin, 10'h1);
        // Back to data-only before continuous read stops
        wr(32'h28, 32'h0);
        continuous_read <= 1'b0;
        tick(3);
        rd(32'h3C, 32'h0);
    endtask : t_ready

    initial begin
        reset = 1'b1;
        result_ready = 1'b0;
        continuous_read = 1'b1;
        serial_data = 1'b0;
        pin_ext = 8'hA5;
        t_reset();
        t_control();
        t_route();
        t_pins();
        t_ready();
        wr(32'h40, 32'hFF);
        rd(32'h40, 32'h0);
        rd(32'h2C, 32'h94);
        t_reset();
        end_sim();
    end
endmodule : test_excitation_gpio_config_regs
